// ==== inc/ddc_defs.svh ====
// Purpose: constants for the direct data channel link
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: offsets are byte addresses
`ifndef DDC_DEFS_SVH
`define DDC_DEFS_SVH
`define DDC_OFS_CMD 12'h000
`define DDC_OFS_STAT 12'h004
`define DDC_OFS_TXD 12'h008
`define DDC_OFS_RXD 12'h00c
`define DDC_OFS_CTRL 12'h010
`define DDC_OFS_TEST 12'h014
`define DDC_CMD_RDREQ 4'h1
`define DDC_CMD_WRREQ 4'h2
`define DDC_CMD_EOTRST 4'h3
`define DDC_CMD_CLRERR 4'h4
`define DDC_DCH_ERR 4'h1
`define DDC_DCH_EOT 4'h2
`define DDC_DCH_RDREQ 4'h3
`define DDC_DCH_WRREQ 4'h4
`define DDC_GROUP_MARK_WITH_WORD_MARK 8'hbf
`endif

// ==== inc/ddc_pkg.sv ====
// Purpose: types for the direct data channel link
// Assumes: constants live in ddc_defs.svh
// Notes: none
package ddc_pkg;
  typedef enum logic [1:0] {DDC_IDLE, DDC_SEND, DDC_RECV} ddc_mode_t;
  typedef struct packed {
    ddc_mode_t mode;
    logic loadMode;
    logic eotLocal;
    logic errLocal;
    logic rdReqOut;
    logic wrReqOut;
    logic eotRstOut;
    logic sentReset;
    logic [7:0] txChar;
    logic txStb;
    logic [7:0] rxChar;
    logic rxValid;
    logic [31:0] hrdata;
    logic branchTaken;
    logic adapterBusy;
  } ddc_state_t;
endpackage

// ==== design/ddc_sync.sv ====
// Purpose: two-flop synchroniser for pin inputs
// Assumes: one clock, synchronous active-high reset
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module ddc_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      stage1_q <= '0;
      dout <= '0;
    end else begin
      stage1_q <= din;
      dout <= stage1_q;
    end
  end
endmodule

// ==== design/ddc_link.sv ====
// Purpose: direct data channel end with AHB-Lite register access
// Assumes: peer drives its pins asynchronously; 10 MHz clock
// Notes: characters are 8 bits: word mark, zone B A, numeric 8421
//
// Summary of operation
// - Characters cross one at a time, bits parallel, with word mark and parity.
// - While channel active the serial adapter is reported busy to other units.
// - Read-request command raises the read-request line, peer tests with code 3.
// - Write-request command raises the write-request line, peer tests with code 4.
// - Reset command pulses a line clearing the peer end-of-transmission circuitry.
// - A reset signal must precede every read or write data transfer.
// - Reset signal is sent whenever the peer is started or restarted.
// - Branch test checks selected peer condition and reports branch taken.
// - Signal-control commands leave stored word marks unchanged.
// - End-of-transmission set by group mark with word mark; clear before transfer.
// - Peer read request cleared by our write-data or by our receive start.
// - Move mode drops word marks; load mode carries them; both ends agree.
// - Transmission error sets a check flag the peer tests with code 1.
`timescale 1ns/1ps
`include "ddc_defs.svh"
module ddc_link import ddc_pkg::*; (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [8:0] linkDataOut,
  output logic linkStrobeOut,
  input wire logic [8:0] linkDataIn,
  input wire logic linkStrobeIn,
  output logic rdReqOut,
  output logic wrReqOut,
  output logic eotResetOut,
  output logic errOut,
  output logic eotOut,
  input wire logic peerRdReq,
  input wire logic peerWrReq,
  input wire logic peerEotReset,
  input wire logic peerErr,
  input wire logic peerEot,
  input wire logic peerStarted,
  output logic adapterBusy
);
  // ********************************
  // Pin synchronisers
  // ********************************
  logic [15:0] pinsRaw;
  logic [15:0] pins;
  assign pinsRaw = {peerStarted, peerEot, peerErr, peerEotReset, peerWrReq, peerRdReq,
                    linkStrobeIn, linkDataIn};
  ddc_sync #(.W(16)) u_sync (.clock(clock), .rst(rst), .din(pinsRaw), .dout(pins));
  logic [8:0] rxBits;
  logic rxStb, pRd, pWr, pEotRst, pErr, pEot, pStart;
  assign rxBits = pins[8:0];
  assign {pStart, pEot, pErr, pEotRst, pWr, pRd, rxStb} = pins[15:9];
  logic rxStbLast_q, pStartLast_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      rxStbLast_q <= 1'b0;
      pStartLast_q <= 1'b0;
    end else begin
      rxStbLast_q <= rxStb;
      pStartLast_q <= pStart;
    end
  end
  logic rxEdge, startEdge;
  assign rxEdge = rxStb & ~rxStbLast_q;
  assign startEdge = pStart & ~pStartLast_q;

  // ********************************
  // AHB-Lite address phase capture
  // ********************************
  logic wrPend_q, rdPend_q;
  logic [11:0] addr_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      addr_q <= 12'h000;
    end else if (hready) begin
      wrPend_q <= hsel & htrans[1] & hwrite;
      rdPend_q <= hsel & htrans[1] & ~hwrite;
      addr_q <= haddr;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ********************************
  // Register decode
  // ********************************
  // Unmapped offsets decode to nothing: writes dropped, reads zero
  logic cmdWr, txWr, ctrlWr, testWr, rxRd;
  assign cmdWr = wrPend_q && addr_q == `DDC_OFS_CMD;
  assign txWr = wrPend_q && addr_q == `DDC_OFS_TXD;
  assign ctrlWr = wrPend_q && addr_q == `DDC_OFS_CTRL;
  assign testWr = wrPend_q && addr_q == `DDC_OFS_TEST;
  assign rxRd = rdPend_q && addr_q == `DDC_OFS_RXD;

  // ********************************
  // Channel state
  // ********************************
  ddc_state_t s_q, s_d;
  logic peerSel;
  always_comb begin
    s_d = s_q;
    s_d.txStb = 1'b0;
    s_d.eotRstOut = 1'b0;
    peerSel = 1'b0;
    if (cmdWr) begin
      // Commands touch only link lines and the sentReset flag, never stored data
      case (hwdata[3:0])
        `DDC_CMD_RDREQ: s_d.rdReqOut = 1'b1;
        `DDC_CMD_WRREQ: s_d.wrReqOut = 1'b1;
        `DDC_CMD_EOTRST: begin
          s_d.eotRstOut = 1'b1;
          s_d.sentReset = 1'b1;
        end
        `DDC_CMD_CLRERR: s_d.errLocal = 1'b0;
        default: ;
      endcase
    end
    // Peer start is seen two cycles late, through the synchroniser
    if (startEdge) begin
      s_d.eotRstOut = 1'b1;
      s_d.sentReset = 1'b1;
    end
    if (ctrlWr) begin
      s_d.loadMode = hwdata[2];
      // Transfer only starts after a reset was sent and EOT is clear
      if (hwdata[1:0] != 2'b00 && s_q.sentReset && !s_q.eotLocal) begin
        s_d.mode = hwdata[0] ? DDC_SEND : DDC_RECV;
        s_d.sentReset = 1'b0;
        if (hwdata[0])
          s_d.wrReqOut = 1'b0;
        else
          s_d.rdReqOut = 1'b0;
      end else if (hwdata[1:0] == 2'b00) begin
        s_d.mode = DDC_IDLE;
      end
    end
    // Our write-data clears the peer's read request here
    if (s_q.mode == DDC_SEND)
      s_d.rdReqOut = 1'b0;
    // Clear comes before the mark checks below, so a mark that same cycle wins
    if (pEotRst)
      s_d.eotLocal = 1'b0;
    if (txWr && s_q.mode == DDC_SEND) begin
      s_d.txChar = s_q.loadMode ? hwdata[7:0] : {1'b0, hwdata[6:0]};
      s_d.txStb = 1'b1;
      if (hwdata[7:0] == `DDC_GROUP_MARK_WITH_WORD_MARK) begin
        s_d.eotLocal = 1'b1;
        s_d.mode = DDC_IDLE;
      end
    end
    if (rxRd)
      s_d.rxValid = 1'b0;
    // Set after the read clear so an arriving character wins that cycle
    if (rxEdge && s_q.mode == DDC_RECV) begin
      if (^rxBits != 1'b1)
        s_d.errLocal = 1'b1;
      s_d.rxChar = s_q.loadMode ? rxBits[7:0] : {1'b0, rxBits[6:0]};
      s_d.rxValid = 1'b1;
      if (rxBits[7:0] == `DDC_GROUP_MARK_WITH_WORD_MARK) begin
        s_d.eotLocal = 1'b1;
        s_d.mode = DDC_IDLE;
      end
    end
    s_d.adapterBusy = s_d.mode != DDC_IDLE;
    if (testWr) begin
      case (hwdata[3:0])
        `DDC_DCH_ERR: peerSel = pErr;
        `DDC_DCH_EOT: peerSel = pEot;
        `DDC_DCH_RDREQ: peerSel = pRd;
        `DDC_DCH_WRREQ: peerSel = pWr;
        default: peerSel = 1'b0;
      endcase
      s_d.branchTaken = peerSel;
    end
    // Read data latched in the address phase so it stands for the data phase
    s_d.hrdata = 32'h0000_0000;
    if (hsel && htrans[1] && !hwrite && hready) begin
      case (haddr)
        `DDC_OFS_STAT: s_d.hrdata = {22'h000000, s_q.adapterBusy, s_q.branchTaken,
                                     s_q.rxValid, s_q.sentReset, s_q.errLocal,
                                     s_q.eotLocal, s_q.wrReqOut, s_q.rdReqOut,
                                     s_q.mode};
        `DDC_OFS_RXD: s_d.hrdata = {24'h000000, s_q.rxChar};
        `DDC_OFS_CTRL: s_d.hrdata = {29'h00000000, s_q.loadMode, 2'b00};
        default: s_d.hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ********************************
  // State register
  // ********************************
  always_ff @(posedge clock) begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ********************************
  // Outputs
  // ********************************
  assign hrdata = s_q.hrdata;
  // Odd parity over all nine lines, formed from the registered character
  assign linkDataOut = {~^s_q.txChar, s_q.txChar};
  assign linkStrobeOut = s_q.txStb;
  assign rdReqOut = s_q.rdReqOut;
  assign wrReqOut = s_q.wrReqOut;
  assign eotResetOut = s_q.eotRstOut;
  assign errOut = s_q.errLocal;
  assign eotOut = s_q.eotLocal;
  assign adapterBusy = s_q.adapterBusy;
endmodule

// ==== bench/ddc_monitor.sv ====
// Purpose: port checker for the link end
// Assumes: one clock, sync active-high reset
// Notes: bound from the bench top file
`timescale 1ns/1ps
module ddc_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [8:0] linkDataOut,
  input wire logic linkStrobeOut,
  input wire logic eotResetOut,
  input wire logic adapterBusy,
  input wire logic peerStarted
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_start; $rose(peerStarted); endsequence
  sequence s_pulse; eotResetOut ##1 !eotResetOut; endsequence
  property p_rdy; hreadyout; endproperty
  a_rdy: assert property (p_rdy) else $error("bus stalled");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("error response");
  property p_stb; linkStrobeOut |=> !linkStrobeOut; endproperty
  a_stb: assert property (p_stb) else $error("strobe too long");
  property p_par; linkStrobeOut |-> ^linkDataOut; endproperty
  a_par: assert property (p_par) else $error("even parity sent");
  property p_busy; linkStrobeOut |-> $past(adapterBusy); endproperty
  a_busy: assert property (p_busy) else $error("char while idle");
  property p_erst; eotResetOut |=> !eotResetOut; endproperty
  a_erst: assert property (p_erst) else $error("reset pulse too long");
  // Peer start crosses a synchroniser first
  property p_sync; s_start |-> !eotResetOut; endproperty
  a_sync: assert property (p_sync) else $error("early start pulse");
  property p_start; s_start |-> ##[1:6] s_pulse; endproperty
  a_start: assert property (p_start) else $error("no pulse on start");
endmodule

// ==== bench/ddc_peer.sv ====
// Purpose: peer system at the far end of the cable
// Assumes: lines change just after a rising edge
// Notes: released data lines show the inverse value
`timescale 1ns/1ps
module ddc_peer (
  input wire logic clock,
  input wire logic [8:0] linkDataOut,
  input wire logic linkStrobeOut,
  input wire logic eotResetOut,
  output logic [8:0] linkDataIn,
  output logic linkStrobeIn,
  output logic peerErr,
  output logic peerEot,
  output logic peerRdReq,
  output logic peerWrReq,
  output logic peerEotReset,
  output logic peerStarted
);
  // ****
  // Peer state
  // ****
  logic [3:0] lv = 4'h0;
  logic [8:0] got = 9'h0;
  int nRst = 0;
  initial begin
    linkDataIn = 9'h0;
    linkStrobeIn = 1'b0;
    peerStarted = 1'b0;
    peerEotReset = 1'b0;
  end
  assign {peerErr, peerEot, peerRdReq, peerWrReq} = lv;
  always @(posedge clock) begin
    if (linkStrobeOut) got <= linkDataOut;
    if (eotResetOut) begin
      lv[2] <= 1'b0;
      nRst <= nRst + 1;
    end
  end
  // Slow sender: data set four cycles before the strobe, strobe held four cycles
  task send(input logic [8:0] c);
    linkDataIn <= c;
    repeat (4) @(posedge clock);
    linkStrobeIn <= 1'b1;
    repeat (4) @(posedge clock);
    linkStrobeIn <= 1'b0;
    linkDataIn <= ~c;
  endtask
  // One-cycle reset of the far end-of-transmission indicator
  task pulseReset();
    peerEotReset <= 1'b1;
    @(posedge clock);
    peerEotReset <= 1'b0;
  endtask
endmodule

// ==== bench/tb.sv ====
// Purpose: bench for the link end
// Assumes: zero-wait slave, one master
// Notes: scenarios are tasks
`timescale 1ns/1ps
`include "ddc_defs.svh"
`define CK(n, e, s) begin comparisons++; if ((s) !== (e)) begin nMismatch++; \
  $display("FAIL %s exp %h got %h", n, e, s); end end
module tb;
  logic clock, rst, hsel, hwrite, hreadyout, hresp, linkStrobeOut, linkStrobeIn;
  logic rdReqOut, wrReqOut, eotResetOut, errOut, eotOut, adapterBusy, peerEotReset;
  logic peerRdReq, peerWrReq, peerErr, peerEot, peerStarted;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [8:0] linkDataOut, linkDataIn;
  int nMismatch, comparisons, cyc, n;
  ddc_link DUT (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .linkDataOut(linkDataOut),
    .linkStrobeOut(linkStrobeOut), .linkDataIn(linkDataIn), .linkStrobeIn(linkStrobeIn),
    .rdReqOut(rdReqOut), .wrReqOut(wrReqOut), .eotResetOut(eotResetOut), .errOut(errOut),
    .eotOut(eotOut), .peerRdReq(peerRdReq), .peerWrReq(peerWrReq),
    .peerEotReset(peerEotReset), .peerErr(peerErr), .peerEot(peerEot),
    .peerStarted(peerStarted), .adapterBusy(adapterBusy));
  ddc_peer P (.clock(clock), .linkDataOut(linkDataOut), .linkStrobeOut(linkStrobeOut),
    .eotResetOut(eotResetOut), .linkDataIn(linkDataIn), .linkStrobeIn(linkStrobeIn),
    .peerErr(peerErr), .peerEot(peerEot), .peerRdReq(peerRdReq), .peerWrReq(peerWrReq),
    .peerEotReset(peerEotReset), .peerStarted(peerStarted));
  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      nMismatch++;
      conclude();
    end
  end
  // ****
  // Bus and closing
  // ****
  task bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task conclude();
    $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task tInit();
    bus(12'h020, 1'b1, 32'hffffffff);
    bus(12'h020, 1'b0, 32'h0);
    `CK("unmapped", 32'h0, rd)
    bus(`DDC_OFS_CTRL, 1'b1, 32'h1);
    bus(`DDC_OFS_STAT, 1'b0, 32'h0);
    `CK("start refused", 2'h0, rd[1:0])
    $display("init done");
  endtask
  task tSig();
    n = P.nRst;
    bus(`DDC_OFS_CMD, 1'b1, `DDC_CMD_RDREQ);
    bus(`DDC_OFS_CMD, 1'b1, `DDC_CMD_WRREQ);
    bus(`DDC_OFS_CMD, 1'b1, `DDC_CMD_EOTRST);
    repeat (2) @(negedge clock);
    `CK("rdReq", 1'b1, rdReqOut)
    `CK("wrReq", 1'b1, wrReqOut)
    `CK("eot pulses", n + 1, P.nRst)
    $display("signal control done");
  endtask
  task tBranch();
    for (int d = 1; d <= 4; d++) begin
      for (int v = 0; v < 2; v++) begin
        P.lv <= v ? 4'h8 >> (d - 1) : 4'h0;
        repeat (4) @(posedge clock);
        bus(`DDC_OFS_TEST, 1'b1, d);
        bus(`DDC_OFS_STAT, 1'b0, 32'h0);
        `CK("branch", v[0], rd[8])
      end
    end
    P.lv <= 4'h0;
    $display("branch done");
  endtask
  task tSend();
    logic [8:0] exp [2] = '{9'h0c1, 9'h141};
    for (int i = 0; i < 2; i++) begin
      bus(`DDC_OFS_CTRL, 1'b1, 32'h0);
      bus(`DDC_OFS_CMD, 1'b1, `DDC_CMD_EOTRST);
      bus(`DDC_OFS_CTRL, 1'b1, i ? 32'h1 : 32'h5);
      bus(`DDC_OFS_TXD, 1'b1, 32'hc1);
      repeat (3) @(negedge clock);
      `CK("busy", 1'b1, adapterBusy)
      `CK("rdReq cleared", 1'b0, rdReqOut)
      `CK("sent char", exp[i], P.got)
    end
    bus(`DDC_OFS_CTRL, 1'b1, 32'h0);
    $display("send done");
  endtask
  task tRecv();
    bus(`DDC_OFS_CMD, 1'b1, `DDC_CMD_EOTRST);
    bus(`DDC_OFS_CTRL, 1'b1, 32'h6);
    P.send(9'h0c1);
    bus(`DDC_OFS_RXD, 1'b0, 32'h0);
    `CK("rx char", 8'hc1, rd[7:0])
    P.send(9'h1c1);
    @(negedge clock);
    `CK("parity err", 1'b1, errOut)
    bus(`DDC_OFS_CMD, 1'b1, `DDC_CMD_CLRERR);
    @(negedge clock);
    `CK("err clear", 1'b0, errOut)
    $display("receive done");
  endtask
  task tEot();
    P.send(9'h0bf);
    @(negedge clock);
    `CK("eot on rx mark", 1'b1, eotOut)
    bus(`DDC_OFS_CMD, 1'b1, `DDC_CMD_EOTRST);
    bus(`DDC_OFS_CTRL, 1'b1, 32'h5);
    bus(`DDC_OFS_STAT, 1'b0, 32'h0);
    `CK("start while eot", 2'h0, rd[1:0])
    P.pulseReset();
    repeat (4) @(negedge clock);
    `CK("eot cleared", 1'b0, eotOut)
    bus(`DDC_OFS_CTRL, 1'b1, 32'h5);
    bus(`DDC_OFS_TXD, 1'b1, 32'hbf);
    repeat (3) @(negedge clock);
    `CK("mark sent", 9'h0bf, P.got)
    `CK("eot on tx mark", 1'b1, eotOut)
    bus(`DDC_OFS_STAT, 1'b0, 32'h0);
    `CK("idle after mark", 2'h0, rd[1:0])
    $display("end of transmission done");
  endtask
  task tStart();
    n = P.nRst;
    P.peerStarted <= 1'b1;
    repeat (8) @(negedge clock);
    `CK("start pulse", n + 1, P.nRst)
    $display("peer start done");
  endtask
  initial begin
    {hsel, htrans, haddr, hwrite, hwdata} = '0;
    {cyc, nMismatch, comparisons} = '0;
    hsize = 3'h2;
    rst = 1'b1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    hsel <= 1'b1;
    tInit();
    tSig();
    tBranch();
    tSend();
    tRecv();
    tEot();
    tStart();
    conclude();
  end
endmodule
bind ddc_link ddc_monitor M (.clock, .rst, .hreadyout, .hresp, .linkDataOut,
  .linkStrobeOut, .eotResetOut, .adapterBusy, .peerStarted);
